// file: verilog/phy_mgmt_write_port.sv
// write-only phy management port driven by the configuration loader
// Summary of operation
// [R1] only loader port reaches these registers
// [R2] access register write starts management cycle
// [R3] loader writes data before access register
// [R4] phy address from bits 15:11, reset zero
// [R5] register index from bits 10:6, reset zero
// [R6] loader sets bit 1 on access writes
// [R7] data bits 15:0 write-only, upper reserved
// [R8] write operations only, no read path
// [R9] send clause 22 write frame, busy meanwhile
module phy_mgmt_write_port import phy_mgmt_pkg::*; #(
  parameter int HALF_CYCLES = MDC_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic loader_wr,
  input wire logic [11:0] loader_addr,
  input wire logic [31:0] loader_wdata,
  input wire logic mdio_i,
  output logic mdc,
  output logic mdio_o,
  output logic mdio_oe,
  output logic busy,
  output logic bit1_missing
);
  typedef enum logic [1:0] {IDLE, LOW, HIGH} state_t;

  state_t state_reg;
  state_t state_next;
  logic [15:0] data_reg;
  logic [4:0] phy_addr_reg;
  logic [4:0] target_reg_index_reg;
  logic must_one_reg;
  logic [63:0] shift_reg;
  logic [6:0] bits_reg;
  mdio_pins_t pins_reg;
  mgmt_write_t cmd;
  logic tick;
  logic data_sel;
  logic access_sel;
  logic start;
  logic last_bit;
  logic unused_in;

  // bit clock phase strobes
  logic low_tick;
  logic high_tick;
  logic frame_done;
  // frame image and shifter next values
  logic [PREAMBLE_BITS-1:0] preamble_word;
  logic [FRAME_BITS-1:0] frame_word;
  logic [63:0] shift_next;
  logic [6:0] bits_next;
  mdio_pins_t pins_next;
  // next values of the loader registers
  logic [15:0] data_next;
  logic [4:0] phy_addr_next;
  logic [4:0] target_reg_index_next;
  logic must_one_next;

  // loader port is the only access path, host bus not connected
  assign data_sel = loader_wr && (loader_addr == PHY_MGMT_WRITE_DATA_OFS); // [R1] [R7]
  assign access_sel = loader_wr && (loader_addr == PHY_MGMT_ACCESS_CONTROL_OFS); // [R1]
  // an access write while busy is dropped; the frame in flight is kept
  assign start = access_sel && (state_reg == IDLE); // [R2]
  assign last_bit = (bits_reg == 7'h01);
  assign cmd = {loader_wdata[PHY_ADDR_LSB +: FIELD_W], // [R4]
                loader_wdata[REG_INDEX_LSB +: FIELD_W], // [R5]
                data_reg}; // [R3]
  // busy spans the whole frame, start to last high phase
  assign busy = (state_reg != IDLE); // [R9]
  assign mdc = pins_reg.mdc;
  assign mdio_o = pins_reg.mdio_o;
  assign mdio_oe = pins_reg.mdio_oe;
  assign bit1_missing = !must_one_reg; // [R6]
  // no read path exists for the phy register data
  assign unused_in = mdio_i; // [R8]

  // half period divider, held cleared between frames
  mdc_divider #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_div (
    .mclk(mclk),
    .rst(rst),
    .run(busy),
    .tick(tick)
  );

  // sequencer: low half, high half, repeated per bit
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE: begin
        if (start) begin
          state_next = LOW;
        end
      end
      LOW: begin
        if (tick) begin
          state_next = HIGH;
        end
      end
      HIGH: begin
        if (tick) begin
          state_next = last_bit ? IDLE : LOW;
        end
      end
      default: begin
        state_next = IDLE;
      end
    endcase
  end

  // register writes from the loader; a busy port keeps address, index and bit 1, but data still loads
  assign data_next = data_sel ? loader_wdata[DATA_LSB +: DATA_W] : data_reg; // [R7]
  assign phy_addr_next = start ? cmd.phy_addr : phy_addr_reg; // [R4]
  assign target_reg_index_next = start ? cmd.target_reg_index : target_reg_index_reg; // [R5]
  assign must_one_next = start ? loader_wdata[MUST_ONE_BIT] : must_one_reg; // [R6]

  // data word survives the frame and can serve the next access
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_reg <= PHY_MGMT_WRITE_DATA_RST[15:0];
    end else begin
      data_reg <= data_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      phy_addr_reg <= FIELD_RST;
    end else begin
      phy_addr_reg <= phy_addr_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      target_reg_index_reg <= FIELD_RST;
    end else begin
      target_reg_index_reg <= target_reg_index_next;
    end
  end

  // flag only; a cleared bit does not hold the frame back
  always_ff @(posedge mclk) begin
    if (rst) begin
      must_one_reg <= 1'b0;
    end else begin
      must_one_reg <= must_one_next;
    end
  end

  // bit clock phases of a running frame
  assign low_tick = (state_reg == LOW) && tick;
  assign high_tick = (state_reg == HIGH) && tick;
  assign frame_done = high_tick && last_bit;

  // frame: preamble, start, write opcode, address, index, turnaround, data
  assign preamble_word = {PREAMBLE_BITS{1'b1}};
  assign frame_word = {preamble_word, FRAME_START, FRAME_OP_WRITE, cmd.phy_addr,
                       cmd.target_reg_index, FRAME_TURNAROUND, cmd.data}; // [R9]
  // msb leaves first; shifted once per high phase
  assign shift_next = start ? frame_word :
                      high_tick ? {shift_reg[62:0], 1'b0} : shift_reg;
  assign bits_next = start ? 7'(FRAME_BITS) :
                     high_tick ? bits_reg - 7'h01 : bits_reg;

  // data moves only while mdc is low, so the phy sees it settled at the rise
  always_comb begin
    pins_next = pins_reg;
    if (start) begin
      pins_next.mdc = 1'b0;
      pins_next.mdio_oe = 1'b1;
      pins_next.mdio_o = 1'b1;
    end else if (low_tick) begin
      pins_next.mdc = 1'b1;
    end else if (high_tick) begin
      pins_next.mdc = 1'b0;
      pins_next.mdio_o = shift_reg[62];
      if (frame_done) begin
        pins_next.mdio_oe = 1'b0; // [R9]
        pins_next.mdio_o = 1'b0;
      end
    end else if (state_reg == LOW) begin
      pins_next.mdio_o = shift_reg[63];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_reg <= 64'h0;
    end else begin
      shift_reg <= shift_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bits_reg <= 7'h00;
    end else begin
      bits_reg <= bits_next;
    end
  end

  // pins are registered so the management lines never glitch
  always_ff @(posedge mclk) begin
    if (rst) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= pins_next;
    end
  end
endmodule : phy_mgmt_write_port

// file: pkg/phy_mgmt_pkg.sv
// constants and carriers for the phy management write port
package phy_mgmt_pkg;
  localparam logic [11:0] PHY_MGMT_WRITE_DATA_OFS = 12'h0a4;
  localparam logic [11:0] PHY_MGMT_ACCESS_CONTROL_OFS = 12'h0a8;
  localparam logic [31:0] PHY_MGMT_WRITE_DATA_RST = 32'h0000_0000;
  localparam int DATA_LSB = 0;
  localparam int DATA_W = 16;
  localparam int PHY_ADDR_LSB = 11;
  localparam int REG_INDEX_LSB = 6;
  localparam int FIELD_W = 5;
  localparam int MUST_ONE_BIT = 1;
  localparam logic [4:0] FIELD_RST = 5'h00;
  localparam int MDC_HALF_NS = 200;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MDC_HALF_CYCLES = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREAMBLE_BITS = 32;
  localparam int FRAME_BITS = 64;
  localparam logic [1:0] FRAME_START = 2'b01;
  localparam logic [1:0] FRAME_OP_WRITE = 2'b01;
  localparam logic [1:0] FRAME_TURNAROUND = 2'b10;

  typedef struct packed {
    logic [4:0] phy_addr;
    logic [4:0] target_reg_index;
    logic [15:0] data;
  } mgmt_write_t;

  typedef struct packed {
    logic mdc;
    logic mdio_o;
    logic mdio_oe;
  } mdio_pins_t;
endpackage : phy_mgmt_pkg

// file: verilog/mdc_divider.sv
// enable pulse generator for management clock half periods
module mdc_divider import phy_mgmt_pkg::*; #(
  parameter int HALF_CYCLES = MDC_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  localparam logic [7:0] LAST = 8'(HALF_CYCLES - 1);

  assign tick = run && (cnt_reg == LAST);
  assign cnt_next = (!run || tick) ? 8'h00 : cnt_reg + 8'h01;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : mdc_divider

// file: dv/phy_mgmt_checker.sv
// pin assertions for the phy management write port
module phy_mgmt_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic loader_wr,
  input wire logic [11:0] loader_addr,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic acc = loader_wr && loader_addr == 12'h0a8;
  a_access_starts: assert property (acc && !busy |=> busy) else $error("start");
  a_other_ignored: assert property (loader_wr && !acc && !busy |=> !busy) else $error("stray");
  a_oe_is_busy: assert property (mdio_oe == busy) else $error("oe");
  a_frame_opens: assert property ($rose(busy) |-> !mdc && mdio_o) else $error("open");
  a_frame_ends: assert property ($rose(busy) |-> ##[2:1000] !busy) else $error("hang");
  a_data_mdc_low: assert property (busy && $changed(mdio_o) |-> !mdc) else $error("data");
  a_idle_mdc_low: assert property (!busy |-> !mdc) else $error("mdc");
  c_start: cover property (acc && !busy);
  c_refused: cover property (acc && busy);
  c_end: cover property ($fell(busy));
endmodule : phy_mgmt_checker
bind phy_mgmt_write_port phy_mgmt_checker phy_mgmt_checker_i (.mclk, .rst, .loader_wr,
  .loader_addr, .mdc, .mdio_o, .mdio_oe, .busy);

// file: dv/phy_mgmt_phy_model.sv
// behavioural phy collecting management frames
module phy_mgmt_phy_model (
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  output logic mdio_i,
  output logic [63:0] frame,
  output int nbits
);
  timeunit 1ns;
  timeprecision 1ns;
  // released line floats to the pull-up
  assign mdio_i = mdio_oe ? mdio_o : 1'b1;
  always @(posedge mdio_oe) nbits = 0;
  always @(posedge mdc) if (mdio_oe) begin
    frame = {frame[62:0], mdio_o};
    nbits = nbits + 1;
  end
endmodule : phy_mgmt_phy_model

// file: dv/phy_mgmt_write_port_bench.sv
// self-checking bench for the phy management write port
module phy_mgmt_write_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst = 1'b1, loader_wr = 1'b0, mdio_i, mdc, mdio_o, mdio_oe, busy;
  logic bit1_missing;
  logic [11:0] loader_addr = 12'h000;
  logic [31:0] loader_wdata = 32'h0;
  logic [63:0] frame;
  int nbits, num_errors = 0, compares = 0, cyc = 0;
  always #20 mclk = ~mclk;
  phy_mgmt_write_port #(.HALF_CYCLES(1)) phy_mgmt_write_port_i (.mclk, .rst, .loader_wr,
    .loader_addr, .loader_wdata, .mdio_i, .mdc, .mdio_o, .mdio_oe, .busy, .bit1_missing);
  phy_mgmt_phy_model phy_mgmt_phy_model_i (.mdc, .mdio_o, .mdio_oe, .mdio_i, .frame, .nbits);
  task automatic print_verdict();
    $display("errors %0d of %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(negedge mclk);
    loader_wr = 1'b1;
    loader_addr = a;
    loader_wdata = d;
    @(negedge mclk);
    loader_wr = 1'b0;
  endtask : wr
  task automatic send(logic [4:0] a, logic [4:0] i, logic [15:0] d, bit ld, bit poke);
    if (ld) wr(12'h0a4, {16'hffff, d});
    wr(12'h0a8, {16'h0, a, i, 6'h02});
    if (poke) wr(12'h0a8, 32'hffc2);
    repeat (300) if (busy) @(negedge mclk);
    chk(busy, 64'h0);
    chk(nbits, 64'h40);
    chk(frame, {32'hffffffff, 4'h5, a, i, 2'h2, d});
  endtask : send
  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    chk(bit1_missing, 64'h1);
    send(5'h1f, 5'h00, 16'h0000, 1'b0, 1'b0);
    chk(bit1_missing, 64'h0);
    send(5'h00, 5'h1f, 16'ha55a, 1'b1, 1'b1);
    wr(12'h0ac, 32'hffc2);
    chk(busy, 64'h0);
    print_verdict();
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
endmodule : phy_mgmt_write_port_bench
